/* File: logic/amux_pkg.sv */
// Purpose: constants and carriers for the converter positive-input multiplexer control
// Assumes: 8-bit special-function-register bus, byte addresses as printed
// Notes:   offset registers are on a paged bus; page is decoded outside this block
package amux_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] TEMP_OFFSET_LOW_ADDR  = 8'h85;
	localparam logic [7:0] TEMP_OFFSET_HIGH_ADDR = 8'h86;
	localparam logic [7:0] INPUT_SELECT_ADDR     = 8'hbb;
	// sensor enable shares the reference control register; only its enable bit is kept here
	localparam logic [7:0] SENSOR_CTRL_ADDR      = 8'hd1;

	localparam int CHAN_MSB       = 4;
	localparam int CHAN_W         = 5;
	localparam int SENSOR_EN_BIT  = 2;
	localparam int OFFSET_W       = 10;
	localparam int OFFSET_LOW_LSB = 6;

	localparam logic [4:0] CHAN_RESET    = 5'h1f;
	localparam logic [7:0] READ_ZERO     = 8'h00;

	// ----------------------------------------------------------------
	// channel codes
	// ----------------------------------------------------------------
	localparam logic [4:0] CH_P0_FIRST = 5'h00;
	localparam logic [4:0] CH_P0_LAST  = 5'h07;
	localparam logic [4:0] CH_P1_FIRST = 5'h0d;
	localparam logic [4:0] CH_P1_LAST  = 5'h0f;
	localparam logic [4:0] CH_P2_FIRST = 5'h10;
	localparam logic [4:0] CH_P2_LAST  = 5'h16;
	localparam logic [4:0] CH_TEMP     = 5'h1b;
	localparam logic [4:0] CH_SUPPLY_A = 5'h1c;
	localparam logic [4:0] CH_DIGITAL  = 5'h1d;
	localparam logic [4:0] CH_SUPPLY_B = 5'h1e;
	localparam logic [4:0] CH_GROUND   = 5'h1f;

	// first port 1 pin reachable through the mux
	localparam int P1_PIN_BASE = 5;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic       temp;
		logic       supply;
		logic       digital;
		logic       ground;
	} switch_t;

endpackage

/* File: logic/offset_store.sv */
// Purpose: holds the factory temperature offset word and serves its two bytes
// Assumes: trim word arrives on a port from non-volatile trim logic
// Notes:   read data registered; the word is captured each clock and clears to zero on reset
`timescale 1ns/1ns
module offset_store
	import amux_pkg::*;
(
	input  wire logic                clk_i,       // system clock
	input  wire logic                resetn_i,    // async reset, low
	input  wire logic [OFFSET_W-1:0] trim_i,      // factory measured value
	input  wire logic                sel_high_i,  // 1 high byte, 0 low byte
	output logic      [7:0]          rdata_o      // registered byte
);

	typedef struct packed {
		logic [OFFSET_W-1:0] word;
		logic [7:0]          rdata;
	} store_t;

	store_t st_reg;
	store_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.word = trim_i;
		if (sel_high_i) begin
			st_next.rdata = st_reg.word[OFFSET_W-1:2];
		end else begin
			st_next.rdata = {st_reg.word[1:0], 6'h00};
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata;

endmodule

/* File: logic/adc_input_mux_select.sv */
// Purpose: channel-select register and analog switch decode for the converter positive input
// Assumes: single-cycle sfr strobes; read data valid the cycle after rd
// Notes:   sensor enable bit lives in a small control register of this block
//
// What this block does
// - five-bit read/write channel field in bits 4:0, resets to ground code.
// - bits 7:5 of the select register read zero, writes ignored.
// - codes map to port 0 pins 0-7, port 1 pins 5-7, port 2 pins 0-6.
// - internal codes select sensor, main supply twice, digital supply, ground.
// - sensor stays high impedance while its enable bit is clear.
// - read-only ten-bit offset, bits 9:2 in the high byte register.
// - offset registers hold the production sensor result; the stored word clears to zero on reset.
// - offset low bits sit in bits 7:6, bits 5:0 read zero.
`timescale 1ns/1ns
module adc_input_mux_select
	import amux_pkg::*;
(
	input  wire logic                clk_i,           // system clock 100 MHz
	input  wire logic                resetn_i,        // async reset, low
	input  wire sfr_req_t            sfr_i,           // register bus request
	output logic      [7:0]          rdata_o,         // register read data
	input  wire logic [OFFSET_W-1:0] trim_i,          // factory offset word
	output switch_t                  switch_o,        // positive_input_switch controls
	output logic                     sensor_en_o,     // sensor_enable_bit, drives sensor
	output logic                     sensor_hiz_o     // sensor output high impedance
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RD_SEL    = 2'b01,
		RD_OFFSET = 2'b10
	} rd_src_t;

	typedef struct packed {
		logic [CHAN_W-1:0] positive_channel_code;
		logic              sensor_enable_bit;
		switch_t           sw;
		logic              hiz;
		logic [7:0]        local_rdata;
		rd_src_t           rd_src;
	} mux_state_t;

	mux_state_t st_reg;
	mux_state_t st_next;
	logic [7:0] offset_rdata;
	logic       chan_wr;
	logic       ctrl_wr;

	offset_store u_offset (
		.clk_i      (clk_i),
		.resetn_i   (resetn_i),
		.trim_i     (trim_i),
		.sel_high_i (sfr_i.addr == TEMP_OFFSET_HIGH_ADDR),
		.rdata_o    (offset_rdata)
	);

	// ----------------------------------------------------------------
	// one-hot decode of a channel code
	// ----------------------------------------------------------------
	function automatic switch_t decode(input logic [CHAN_W-1:0] code);
		switch_t s;
		s = '0;
		if (code <= CH_P0_LAST) begin
			s.p0[code[2:0]] = 1'b1;
		end else if (code >= CH_P1_FIRST && code <= CH_P1_LAST) begin
			s.p1[3'(code - CH_P1_FIRST) + 3'(P1_PIN_BASE)] = 1'b1;
		end else if (code >= CH_P2_FIRST && code <= CH_P2_LAST) begin
			s.p2[code[2:0]] = 1'b1;
		end else begin
			case (code)
				CH_TEMP:     s.temp = 1'b1;
				CH_SUPPLY_A: s.supply = 1'b1;
				CH_SUPPLY_B: s.supply = 1'b1;
				CH_DIGITAL:  s.digital = 1'b1;
				CH_GROUND:   s.ground = 1'b1;
				default:     s = '0;
			endcase
		end
		return s;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	assign chan_wr = sfr_i.wr && sfr_i.addr == INPUT_SELECT_ADDR;
	assign ctrl_wr = sfr_i.wr && sfr_i.addr == SENSOR_CTRL_ADDR;

	always_comb begin
		st_next = st_reg;
		if (chan_wr) begin
			// upper bits dropped on purpose
			st_next.positive_channel_code = sfr_i.wdata[CHAN_MSB:0];
		end
		if (ctrl_wr) begin
			st_next.sensor_enable_bit = sfr_i.wdata[SENSOR_EN_BIT];
		end
		// switches follow the register; the caller owns the ground step before the sensor
		st_next.sw  = decode(st_next.positive_channel_code);
		st_next.hiz = !st_next.sensor_enable_bit;
		if (sfr_i.rd) begin
			st_next.rd_src = RD_SEL;
			case (sfr_i.addr)
				INPUT_SELECT_ADDR: st_next.local_rdata =
					{3'b000, st_reg.positive_channel_code};
				SENSOR_CTRL_ADDR: begin
					// other reference control bits belong to a neighbouring unit and read zero here
					st_next.local_rdata                = READ_ZERO;
					st_next.local_rdata[SENSOR_EN_BIT] = st_reg.sensor_enable_bit;
				end
				TEMP_OFFSET_HIGH_ADDR, TEMP_OFFSET_LOW_ADDR: begin
					st_next.rd_src      = RD_OFFSET;
					st_next.local_rdata = READ_ZERO;
				end
				default: st_next.local_rdata = READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg                       <= '0;
			st_reg.positive_channel_code <= CHAN_RESET;
			st_reg.sw.ground             <= 1'b1;
			st_reg.hiz                   <= 1'b1;
			st_reg.rd_src                <= RD_SEL;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// offset byte is registered inside the store, so both paths are flop outputs
	assign rdata_o      = (st_reg.rd_src == RD_OFFSET) ? offset_rdata : st_reg.local_rdata;
	assign switch_o     = st_reg.sw;
	assign sensor_en_o  = st_reg.sensor_enable_bit;
	assign sensor_hiz_o = st_reg.hiz;

endmodule

/* File: bench/adc_input_mux_select_props.sv */
// Purpose: port checks for the input mux control
// Assumes: one-cycle strobes
// Notes:   trim held steady by the bench
`timescale 1ns/1ns
module amux_chk
	import amux_pkg::*;
(
	input wire logic                clk_i,        // clock
	input wire logic                resetn_i,     // reset, low
	input wire sfr_req_t            sfr_i,        // bus
	input wire logic [7:0]          rdata_o,      // read data
	input wire logic [OFFSET_W-1:0] trim_i,       // offset
	input wire switch_t             switch_o,     // switches
	input wire logic                sensor_en_o,  // enable
	input wire logic                sensor_hiz_o  // hiz
);
	wire       ws = sfr_i.wr && sfr_i.addr == INPUT_SELECT_ADDR;
	wire       rh = sfr_i.rd && sfr_i.addr == TEMP_OFFSET_HIGH_ADDR;
	wire       rl = sfr_i.rd && sfr_i.addr == TEMP_OFFSET_LOW_ADDR;
	wire [4:0] cd = sfr_i.wdata[4:0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	hiz_follows_a: assert property (sensor_hiz_o == !sensor_en_o) else $error("hiz wrong");
	one_hot_a: assert property ($onehot0(switch_o)) else $error("two switches");
	rsv_off_a: assert property (ws && (cd inside {[5'h08:5'h0c], [5'h17:5'h1a]}) |=> switch_o == '0)
		else $error("reserved closed a switch");
	temp_sel_a: assert property (ws && cd == CH_TEMP |=> switch_o.temp) else $error("no sensor");
	p0_sel_a: assert property (ws && cd < 5'h08 |=> switch_o.p0 == 8'h01 << $past(cd))
		else $error("port 0 pin wrong");
	keep_sel_a: assert property (!ws |=> $stable(switch_o)) else $error("switch moved");
	hi_byte_a: assert property (rh |=> rdata_o == $past(trim_i[9:2], 2)) else $error("high byte");
	lo_byte_a: assert property (rl |=> rdata_o == {$past(trim_i[1:0], 2), 6'h00}) else $error("low byte");
	top_zero_a: assert property (sfr_i.rd && sfr_i.addr == INPUT_SELECT_ADDR |=> rdata_o[7:5] == 3'h0)
		else $error("upper bits set");
	cover property (ws && cd == CH_TEMP);
	cover property (rh);
	cover property ($rose(sensor_en_o));
endmodule
bind adc_input_mux_select amux_chk chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_i(sfr_i),
	.rdata_o(rdata_o), .trim_i(trim_i), .switch_o(switch_o), .sensor_en_o(sensor_en_o),
	.sensor_hiz_o(sensor_hiz_o));

/* File: bench/adc_input_mux_select_tb_top.sv */
// Purpose: register-level bench for the input mux control
// Assumes: read data one cycle after rd
// Notes:   trim constant so offset bytes are known
`timescale 1ns/1ns
module adc_input_mux_select_tb_top
	import amux_pkg::*;
;
	logic                clk_i = 0;
	logic                resetn_i = 0;
	sfr_req_t            sfr_i = '0;
	logic [OFFSET_W-1:0] trim_i = 10'h29d;
	logic [7:0]          rdata_o;
	switch_t             switch_o;
	logic                sensor_en_o;
	logic                sensor_hiz_o;
	int                  err_count = 0;
	int                  samples_checked = 0;
	int                  cyc = 0;
	adc_input_mux_select dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_i(sfr_i), .rdata_o(rdata_o),
		.trim_i(trim_i), .switch_o(switch_o), .sensor_en_o(sensor_en_o), .sensor_hiz_o(sensor_hiz_o));
	initial forever #5 clk_i = ~clk_i;
	task automatic give_verdict;
		$display("mismatches %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// a hung bus would stall forever; the whole run needs about 160 cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: byte %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_sw(input switch_t got, input switch_t exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: switches %h want %h", $time, got, exp);
		end
	endtask
	function automatic switch_t exp_sw(input logic [4:0] c);
		switch_t s = '0;
		if (c < 5'h08) s.p0[c[2:0]] = 1'b1;
		else if (c inside {[5'h0d:5'h0f]}) s.p1[c[2:0]] = 1'b1;
		else if (c inside {[5'h10:5'h16]}) s.p2[c[2:0]] = 1'b1;
		s.temp = c == 5'h1b;
		s.supply = c == 5'h1c || c == 5'h1e;
		s.digital = c == 5'h1d;
		s.ground = c == 5'h1f;
		return s;
	endfunction
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sfr_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		sfr_i <= '0;
		#1;
	endtask
	task automatic get(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		sfr_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		sfr_i <= '0;
		#1 chk8(rdata_o, exp);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		#1 chk_sw(switch_o, exp_sw(5'h1f));
		chk8({6'h00, sensor_hiz_o, sensor_en_o}, 8'h02);
		get(INPUT_SELECT_ADDR, 8'h1f);
		get(TEMP_OFFSET_HIGH_ADDR, 8'ha7);
		get(TEMP_OFFSET_LOW_ADDR, 8'h40);
		put(TEMP_OFFSET_HIGH_ADDR, 8'h00);
		get(TEMP_OFFSET_HIGH_ADDR, 8'ha7);
		get(8'h40, 8'h00);
		for (int c = 0; c < 32; c++) begin
			if (c == 27) put(INPUT_SELECT_ADDR, 8'h1f);
			put(INPUT_SELECT_ADDR, {3'h7, c[4:0]});
			chk_sw(switch_o, exp_sw(c[4:0]));
			get(INPUT_SELECT_ADDR, {3'h0, c[4:0]});
		end
		put(SENSOR_CTRL_ADDR, 8'hff);
		chk8({6'h00, sensor_hiz_o, sensor_en_o}, 8'h01);
		get(SENSOR_CTRL_ADDR, 8'h04);
		put(SENSOR_CTRL_ADDR, 8'hfb);
		chk8({6'h00, sensor_hiz_o, sensor_en_o}, 8'h02);
		give_verdict();
	end
endmodule
